// >>> logic/timer8_pkg.sv
// Constants for the 8-bit timer with two compare channels.
// Assumes a 32-bit AXI4-Lite register port and one 100 MHz core clock.
package timer8_pkg;
   // ************************************************************
   // Register byte offsets
   // ************************************************************
   localparam int ADDR_WIDTH = 5;
   localparam logic [4:0] OFF_CTRL_A = 5'h00;
   localparam logic [4:0] OFF_CTRL_B = 5'h04;
   localparam logic [4:0] OFF_COUNT = 5'h08;
   localparam logic [4:0] OFF_CMP_A = 5'h0C;
   localparam logic [4:0] OFF_CMP_B = 5'h10;
   localparam logic [4:0] OFF_FLAGS = 5'h14;
   // ************************************************************
   // Field positions and reset values
   // ************************************************************
   localparam int POS_ACTION_A = 6;
   localparam int POS_ACTION_B = 4;
   localparam int POS_MODE_BIT2 = 3;
   localparam int POS_OVF = 0;
   localparam int POS_MATCH_A = 1;
   localparam int POS_MATCH_B = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [7:0] COUNT_BOTTOM = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ************************************************************
   // Waveform modes and actions
   // ************************************************************
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_PC_MAX = 3'h1;
   localparam logic [2:0] MODE_CTC = 3'h2;
   localparam logic [2:0] MODE_FAST_MAX = 3'h3;
   localparam logic [2:0] MODE_PC_CMP = 3'h5;
   localparam logic [2:0] MODE_FAST_CMP = 3'h7;
   localparam logic [1:0] ACT_OFF = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   // ************************************************************
   // Clock select codes and prescaler masks
   // ************************************************************
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_DIV1 = 3'h1;
   localparam logic [2:0] CS_DIV8 = 3'h2;
   localparam logic [2:0] CS_DIV64 = 3'h3;
   localparam logic [2:0] CS_DIV256 = 3'h4;
   localparam logic [2:0] CS_DIV1024 = 3'h5;
   localparam logic [2:0] CS_EXT_FALL = 3'h6;
   localparam logic [2:0] CS_EXT_RISE = 3'h7;
   localparam logic [9:0] MASK_DIV8 = 10'h007;
   localparam logic [9:0] MASK_DIV64 = 10'h03F;
   localparam logic [9:0] MASK_DIV256 = 10'h0FF;
   localparam logic [9:0] MASK_DIV1024 = 10'h3FF;
endpackage : timer8_pkg

// >>> logic/timer8_tick_gen.sv
// Prescaler and external pin edge detector producing the timer tick.
// Assumes the external pin is asynchronous to the core clock.
`timescale 1ns/10ps
module timer8_tick_gen
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // Control
   input wire logic [2:0] clock_select_in,
   input wire logic ext_clk_pin_in,
   // Tick
   output logic tick_out
);
   logic [9:0] pre_cnt_reg;
   logic sync1_reg;
   logic sync2_reg;
   logic prev_reg;

   // ************************************************************
   // Free prescaler and pin synchroniser
   // ************************************************************
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pre_cnt_reg <= 10'h000;
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 10'h001;
         sync1_reg <= ext_clk_pin_in;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   // ************************************************************
   // Source selection
   // ************************************************************
   wire logic rise_w = sync2_reg & ~prev_reg;
   wire logic fall_w = ~sync2_reg & prev_reg;
   wire logic d8_w = (pre_cnt_reg & MASK_DIV8) == MASK_DIV8;
   wire logic d64_w = (pre_cnt_reg & MASK_DIV64) == MASK_DIV64;
   wire logic d256_w = (pre_cnt_reg & MASK_DIV256) == MASK_DIV256;
   wire logic d1024_w = (pre_cnt_reg & MASK_DIV1024) == MASK_DIV1024;

   assign tick_out = (clock_select_in == CS_DIV1) ? 1'b1 :
                     (clock_select_in == CS_DIV8) ? d8_w :
                     (clock_select_in == CS_DIV64) ? d64_w :
                     (clock_select_in == CS_DIV256) ? d256_w :
                     (clock_select_in == CS_DIV1024) ? d1024_w :
                     (clock_select_in == CS_EXT_FALL) ? fall_w :
                     (clock_select_in == CS_EXT_RISE) ? rise_w : 1'b0;
endmodule : timer8_tick_gen

// >>> logic/timer8_wave.sv
// Summary of operation
// - Tick is an enable, single core clock
// - Nonzero action overrides pin; software sets direction
// - Channel A non-PWM: off, toggle, clear, set
// - Channel A fast PWM actions, toggle needs bit2
// - Channel A phase correct actions, toggle needs bit2
// - Channel A compare at top: top action only
// - Channel B non-PWM: off, toggle, clear, set
// - Channel B fast PWM actions; action 1 reserved
// - Channel B phase correct actions; action 1 reserved
// - Channel B compare at top: top action only
// - Control A bits 3:2 read zero
// - Three-bit mode from two registers
// - Mode encodings set sequence and top source
// - Compare update time and overflow point per mode
// - Match flags; compare A top clears counter in CTC and fast PWM, reverses it in phase correct
// - Clock select: stop, divided, external edges
// - Fast PWM counts to top then clears
// - Phase correct reverses, holds top one tick
//
// Timer top with AXI4-Lite register slave and two compare outputs.
// Assumes a synchronous AXI4-Lite master on the core clock.
`timescale 1ns/10ps
module timer8_wave
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // AXI4-Lite write
   input wire logic [ADDR_WIDTH-1:0] awaddr_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   input wire logic wvalid_in,
   output logic wready_out,
   output logic [1:0] bresp_out,
   output logic bvalid_out,
   input wire logic bready_in,
   // AXI4-Lite read
   input wire logic [ADDR_WIDTH-1:0] araddr_in,
   input wire logic arvalid_in,
   output logic arready_out,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic rvalid_out,
   input wire logic rready_in,
   // Pins
   input wire logic ext_clk_pin_in,
   output logic compare_out_a_out,
   output logic compare_out_b_out,
   output logic override_a_out,
   output logic override_b_out,
   // Status
   output logic [2:0] flags_out
);
   // ************************************************************
   // Storage
   // ************************************************************
   logic [7:0] ctrl_a_reg;
   logic [3:0] ctrl_b_reg;
   logic [7:0] count_value_reg;
   logic [7:0] cmp_buf_reg [2];
   logic [7:0] cmp_act_reg [2];
   logic [2:0] flag_reg;
   logic dir_up_reg;
   logic block_reg;
   logic [1:0] oc_reg;
   logic [1:0] ovr_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [ADDR_WIDTH-1:0] aw_addr_reg;
   logic [7:0] w_data_reg;
   logic w_lane0_reg;
   logic tick_w;
   logic [1:0] oc_next [2];

   // ************************************************************
   // Tick source
   // ************************************************************
   timer8_tick_gen u_tick (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .clock_select_in(ctrl_b_reg[2:0]),
      .ext_clk_pin_in(ext_clk_pin_in),
      .tick_out(tick_w)
   );

   // ************************************************************
   // Bus decode
   // ************************************************************
   wire logic [4:0] wa_w = {aw_addr_reg[4:2], 2'b00};
   wire logic [4:0] ra_w = {araddr_in[4:2], 2'b00};
   wire logic do_write_w = ~awready_reg & ~wready_reg & ~bvalid_reg;
   wire logic wr_en_w = do_write_w & w_lane0_reg;
   wire logic wr_ctrl_a_w = wr_en_w & (wa_w == OFF_CTRL_A);
   wire logic wr_ctrl_b_w = wr_en_w & (wa_w == OFF_CTRL_B);
   wire logic wr_count_w = wr_en_w & (wa_w == OFF_COUNT);
   wire logic wr_cmp_a_w = wr_en_w & (wa_w == OFF_CMP_A);
   wire logic wr_cmp_b_w = wr_en_w & (wa_w == OFF_CMP_B);
   wire logic wr_flags_w = wr_en_w & (wa_w == OFF_FLAGS);
   wire logic wa_ok_w = (wa_w <= OFF_FLAGS);
   wire logic ra_ok_w = (ra_w <= OFF_FLAGS);
   wire logic rd_take_w = arvalid_in & arready_reg;
   wire logic [7:0] rd_byte_w =
      (ra_w == OFF_CTRL_A) ? {ctrl_a_reg[7:4], 2'b00, ctrl_a_reg[1:0]} :
      (ra_w == OFF_CTRL_B) ? {4'h0, ctrl_b_reg} :
      (ra_w == OFF_COUNT) ? count_value_reg :
      (ra_w == OFF_CMP_A) ? cmp_buf_reg[0] :
      (ra_w == OFF_CMP_B) ? cmp_buf_reg[1] :
      (ra_w == OFF_FLAGS) ? {5'h00, flag_reg} : RESET_BYTE;

   // ************************************************************
   // Mode decode
   // ************************************************************
   wire logic [2:0] mode_w = {ctrl_b_reg[POS_MODE_BIT2], ctrl_a_reg[1:0]};
   wire logic is_pc_w = (mode_w == MODE_PC_MAX) | (mode_w == MODE_PC_CMP);
   wire logic is_fast_w = (mode_w == MODE_FAST_MAX) | (mode_w == MODE_FAST_CMP);
   wire logic is_pwm_w = is_pc_w | is_fast_w;
   wire logic top_is_a_w = (mode_w == MODE_CTC) | (mode_w == MODE_PC_CMP)
                           | (mode_w == MODE_FAST_CMP);
   wire logic [7:0] top_w = top_is_a_w ? cmp_act_reg[0] : COUNT_MAX;
   wire logic at_top_w = (count_value_reg == top_w);
   wire logic at_max_w = (count_value_reg == COUNT_MAX);
   wire logic at_bot_w = (count_value_reg == COUNT_BOTTOM);
   wire logic top_ev_w = tick_w & at_top_w;
   wire logic up_eff_w = dir_up_reg | at_bot_w;

   // ************************************************************
   // Counter sequence
   // ************************************************************
   wire logic [7:0] inc_w = count_value_reg + 8'h01;
   wire logic [7:0] dec_w = count_value_reg - 8'h01;
   wire logic [7:0] pc_step_w = dir_up_reg ? (at_top_w ? dec_w : inc_w)
                                           : (at_bot_w ? inc_w : dec_w);
   wire logic [7:0] step_w = is_pc_w ? pc_step_w
                                     : (at_top_w ? COUNT_BOTTOM : inc_w);
   wire logic [7:0] count_next = wr_count_w ? w_data_reg
                                 : (tick_w ? step_w : count_value_reg);
   wire logic dir_next = ~is_pc_w ? 1'b1
                         : (tick_w & dir_up_reg & at_top_w) ? 1'b0
                         : (tick_w & ~dir_up_reg & at_bot_w) ? 1'b1 : dir_up_reg;
   wire logic ovf_ev_w = tick_w & ((is_pc_w & ~dir_up_reg & at_bot_w)
                         | ((mode_w == MODE_FAST_CMP) & at_top_w)
                         | (~is_pc_w & (mode_w != MODE_FAST_CMP) & at_max_w));

   // ************************************************************
   // Compare channels
   // ************************************************************
   logic [1:0] match_w;
   logic [1:0] act_w;

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch++) begin : g_chan
         wire logic [1:0] act = (ch == 0) ? ctrl_a_reg[POS_ACTION_A +: 2]
                                          : ctrl_a_reg[POS_ACTION_B +: 2];
         wire logic match = tick_w & ~block_reg
                            & (count_value_reg == cmp_act_reg[ch]);
         wire logic ignore = is_pwm_w & act[1]
                             & (cmp_act_reg[ch] == top_w);
         wire logic toggle_ok = ~is_pwm_w
                                | ((ch == 0) & ctrl_b_reg[POS_MODE_BIT2]);
         wire logic oc = oc_reg[ch];
         wire logic top_val = is_fast_w ? ~act[0] : act[0];
         wire logic pwm_match_val = (is_fast_w | up_eff_w) ? act[0] : ~act[0];
         assign act_w[ch] = |act;
         assign match_w[ch] = match;
         assign oc_next[ch] =
            (act == ACT_OFF) ? {oc, oc} :
            ~is_pwm_w ? (match ? ((act == ACT_TOGGLE) ? {~oc, ~oc}
                                                      : {act[0], act[0]}) : {oc, oc}) :
            (act == ACT_TOGGLE) ? ((toggle_ok & match) ? {~oc, ~oc}
                                                       : {oc, oc}) :
            ignore ? (top_ev_w ? {top_val, top_val} : {oc, oc}) :
            match ? {pwm_match_val, pwm_match_val} :
            (is_fast_w & top_ev_w) ? {top_val, top_val} : {oc, oc};

         // Compare value buffering
         always_ff @(posedge ref_clk_in or negedge rstn_in) begin
            if (!rstn_in) begin
               cmp_buf_reg[ch] <= RESET_BYTE;
               cmp_act_reg[ch] <= RESET_BYTE;
               oc_reg[ch] <= 1'b0;
               ovr_reg[ch] <= 1'b0;
            end else begin
               if ((ch == 0) ? wr_cmp_a_w : wr_cmp_b_w) begin
                  cmp_buf_reg[ch] <= w_data_reg;
               end
               if (~is_pwm_w | top_ev_w) begin
                  cmp_act_reg[ch] <= cmp_buf_reg[ch];
               end
               oc_reg[ch] <= oc_next[ch][0];
               ovr_reg[ch] <= act_w[ch];
            end
         end
      end
   endgenerate

   // ************************************************************
   // Flags: hardware set wins over write-one clear
   // ************************************************************
   wire logic [2:0] set_w = {match_w[1], match_w[0], ovf_ev_w};
   wire logic [2:0] clr_w = wr_flags_w ? w_data_reg[2:0] : 3'h0;
   wire logic [2:0] flag_next = (flag_reg & ~clr_w) | set_w;

   // ************************************************************
   // Timer state
   // ************************************************************
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_a_reg <= RESET_BYTE;
         ctrl_b_reg <= 4'h0;
         count_value_reg <= RESET_BYTE;
         flag_reg <= 3'h0;
         dir_up_reg <= 1'b1;
         block_reg <= 1'b0;
      end else begin
         if (wr_ctrl_a_w) begin
            ctrl_a_reg <= {w_data_reg[7:4], 2'b00, w_data_reg[1:0]};
         end
         if (wr_ctrl_b_w) begin
            ctrl_b_reg <= w_data_reg[3:0];
         end
         count_value_reg <= count_next;
         flag_reg <= flag_next;
         dir_up_reg <= dir_next;
         block_reg <= wr_count_w | (block_reg & ~tick_w);
      end
   end

   // ************************************************************
   // AXI4-Lite handshakes
   // ************************************************************
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         aw_addr_reg <= '0;
         w_data_reg <= RESET_BYTE;
         w_lane0_reg <= 1'b0;
      end else begin
         if (awvalid_in & awready_reg) begin
            awready_reg <= 1'b0;
            aw_addr_reg <= awaddr_in;
         end
         if (wvalid_in & wready_reg) begin
            wready_reg <= 1'b0;
            w_data_reg <= wdata_in[7:0];
            w_lane0_reg <= wstrb_in[0];
         end
         if (do_write_w) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wa_ok_w ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_reg & bready_in) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else begin
         if (rd_take_w) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h000000, rd_byte_w};
            rresp_reg <= ra_ok_w ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_reg & rready_in) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign awready_out = awready_reg;
   assign wready_out = wready_reg;
   assign bvalid_out = bvalid_reg;
   assign bresp_out = bresp_reg;
   assign arready_out = arready_reg;
   assign rvalid_out = rvalid_reg;
   assign rresp_out = rresp_reg;
   assign rdata_out = rdata_reg;
   assign compare_out_a_out = oc_reg[0];
   assign compare_out_b_out = oc_reg[1];
   assign override_a_out = ovr_reg[0];
   assign override_b_out = ovr_reg[1];
   assign flags_out = flag_reg;
endmodule : timer8_wave

// >>> verification/tb_timer8_wave.sv
// Bench for the timer: register port, prescaler and compare pins.
// Assumes the pin model and checker are compiled first.
`timescale 1ns/10ps
module tb_timer8_wave;
   import timer8_pkg::*;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [ADDR_WIDTH-1:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, ext_pin, cmp_a, cmp_b, ovr_a, ovr_b;
   logic pin_a, pin_b;
   logic [1:0] bresp, rresp;
   logic [2:0] flags;
   int n_fail = 0, compares = 0, cyc = 0, t_ar = 0;
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) cyc <= cyc + 1;
   timer8_wave i_timer8_wave (
      .ref_clk_in(ref_clk), .rstn_in(rstn), .awaddr_in(awaddr), .awvalid_in(awvalid),
      .awready_out(awready), .wdata_in(wdata), .wstrb_in(4'h1), .wvalid_in(wvalid),
      .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid), .bready_in(bready),
      .araddr_in(araddr), .arvalid_in(arvalid), .arready_out(arready), .rdata_out(rdata),
      .rresp_out(rresp), .rvalid_out(rvalid), .rready_in(rready), .ext_clk_pin_in(ext_pin),
      .compare_out_a_out(cmp_a), .compare_out_b_out(cmp_b), .override_a_out(ovr_a),
      .override_b_out(ovr_b), .flags_out(flags));
   timer8_pins i_timer8_pins (
      .compare_out_a_in(cmp_a), .compare_out_b_in(cmp_b), .override_a_in(ovr_a),
      .override_b_in(ovr_b), .pin_a_out(pin_a), .pin_b_out(pin_b), .ext_pin_out(ext_pin));
   // ********
   // Shared tasks
   // ********
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task cy(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : cy
   task wr(input logic [4:0] a, input logic [7:0] d);
      logic ad, wd;
      int n;
      ad = 0;
      wd = 0;
      n = 0;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (!ad && awready) begin
            ad = 1;
            awvalid <= 1'b0;
         end
         if (!wd && wready) begin
            wd = 1;
            wvalid <= 1'b0;
         end
      end while (!(ad && wd && bvalid) && n < 50);
      bready <= 1'b0;
      check(n < 50, 1'b1);
   endtask : wr
   task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ad;
      int n;
      ad = 0;
      n = 0;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
         if (!ad && arready) begin
            ad = 1;
            t_ar = cyc;
            arvalid <= 1'b0;
         end
      end while (!(ad && rvalid) && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      check(n < 50, 1'b1);
   endtask : rd
   task rdc(input logic [4:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      check(d, exp);
   endtask : rdc
   function automatic logic pin(input logic b);
      return b ? pin_b : pin_a;
   endfunction : pin
   task cnt(input logic b, input logic v, output int k);
      k = 0;
      while (pin(b) === v && k < 3000) begin
         @(posedge ref_clk);
         k++;
      end
   endtask : cnt
   task runlen(input logic b, output int hi, output int lo);
      cnt(b, 1'b1, hi);
      cnt(b, 1'b0, hi);
      cnt(b, 1'b1, hi);
      cnt(b, 1'b0, lo);
   endtask : runlen
   task setup(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ma,
              input logic [7:0] mb);
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_CTRL_A, 8'h00);
      wr(OFF_CMP_A, ca);
      wr(OFF_CMP_B, cb);
      wr(OFF_CTRL_A, ma);
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRL_B, mb);
      wr(OFF_FLAGS, 8'h07);
   endtask : setup
   // ********
   // Scenarios
   // ********
   task t_regs();
      logic [31:0] d;
      logic [1:0] r;
      rdc(OFF_CTRL_A, 32'h0);
      check(pin_a, 1'b1);
      wr(OFF_CTRL_A, 8'hFF);
      rdc(OFF_CTRL_A, 32'hF3);
      check(ovr_a & ovr_b, 1'b1);
      wr(OFF_CTRL_B, 8'hF8);
      rdc(OFF_CTRL_B, 32'h08);
      rd(5'h18, d, r);
      check(r, RESP_SLVERR);
      wr(OFF_CTRL_A, 8'h00);
      wr(OFF_CTRL_B, 8'h00);
      check(ovr_a | ovr_b, 1'b0);
      $display("test regs done");
   endtask : t_regs
   task t_presc();
      int dv [6] = '{0, 1, 8, 64, 256, 1024};
      logic [31:0] c0, c1;
      logic [1:0] r;
      int e;
      for (int i = 0; i < 6; i++) begin
         wr(OFF_COUNT, 8'h00);
         wr(OFF_CTRL_B, 8'(i));
         rd(OFF_COUNT, c0, r);
         e = t_ar;
         cy(3 * dv[i] + 5);
         rd(OFF_COUNT, c1, r);
         e = t_ar - e;
         if (i < 2) check(c1 - c0, dv[i] * e);
         else check(c1 - c0 == e / dv[i] || c1 - c0 == e / dv[i] + 1, 1'b1);
      end
      for (int k = 0; k < 2; k++) begin
         wr(OFF_CTRL_B, {5'h0, k ? CS_EXT_RISE : CS_EXT_FALL});
         rd(OFF_COUNT, c0, r);
         i_timer8_pins.pulse(5);
         cy(8);
         rd(OFF_COUNT, c1, r);
         check(c1 - c0, 32'd5);
      end
      $display("test prescaler done");
   endtask : t_presc
   task t_ovf();
      int n;
      setup(8'hFE, 8'h02, 8'h00, 8'h00);
      wr(OFF_COUNT, 8'hF0);
      check(flags, 3'b000);
      wr(OFF_CTRL_B, {5'h0, CS_DIV1});
      n = 0;
      while (flags[0] !== 1'b1 && n < 100) begin
         @(posedge ref_clk);
         n++;
      end
      check(flags[1:0], 2'b11);
      check(flags[2], 1'b0);
      cy(4);
      check(flags, 3'b111);
      wr(OFF_CTRL_B, 8'h00);
      wr(OFF_FLAGS, 8'h07);
      cy(1);
      check(flags, 3'b000);
      $display("test overflow done");
   endtask : t_ovf
   task t_wave();
      int hi, lo;
      logic [31:0] c;
      logic [1:0] r;
      setup(8'h05, 8'h02, 8'h52, 8'h01);
      runlen(0, hi, lo);
      check(hi, 6);
      check(lo, 6);
      runlen(1, hi, lo);
      check(hi + lo, 12);
      check(flags, 3'b110);
      rd(OFF_COUNT, c, r);
      check(c <= 32'h5, 1'b1);
      setup(8'h09, 8'h03, 8'h63, 8'h09);
      runlen(0, hi, lo);
      check(hi + lo, 20);
      runlen(1, hi, lo);
      check(hi, 4);
      check(lo, 6);
      check(flags[0], 1'b1);
      setup(8'h0A, 8'h04, 8'h71, 8'h09);
      runlen(0, hi, lo);
      check(hi + lo, 40);
      runlen(1, hi, lo);
      check(hi, 12);
      check(lo, 8);
      check(flags[0], 1'b1);
      $display("test waveforms done");
   endtask : t_wave
   task t_top();
      int e;
      setup(8'hFF, 8'hFF, 8'hF3, 8'h01);
      for (int k = 2; k < 4; k++) begin
         wr(OFF_CTRL_A, {2'(k), 2'(k), 4'h3});
         cy(300);
         e = 0;
         repeat (600) begin
            @(posedge ref_clk);
            if (pin_a !== (k == 2) || pin_b !== (k == 2)) e++;
         end
         check(e, 0);
      end
      $display("test compare at top done");
   endtask : t_top
   task end_sim();
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : end_sim
   initial begin
      cy(2);
      rstn <= 1'b1;
      t_regs();
      t_presc();
      t_ovf();
      t_wave();
      t_top();
      end_sim();
   end
   initial begin
      cy(30000);
      n_fail++;
      end_sim();
   end
endmodule : tb_timer8_wave

// >>> verification/timer8_pins.sv
// Pin side model: port pins with pull-up and an external count source.
// Assumes the bench calls pulse() to make external edges.
`timescale 1ns/10ps
module timer8_pins (
   // Design outputs
   input wire logic compare_out_a_in,
   input wire logic compare_out_b_in,
   input wire logic override_a_in,
   input wire logic override_b_in,
   // Resolved pins
   output logic pin_a_out,
   output logic pin_b_out,
   output logic ext_pin_out
);
   assign pin_a_out = override_a_in ? compare_out_a_in : 1'b1;
   assign pin_b_out = override_b_in ? compare_out_b_in : 1'b1;
   initial ext_pin_out = 1'b1;
   // Low pulses off the clock grid
   task pulse(input int n);
      repeat (n) begin
         #37 ext_pin_out = 1'b0;
         #41 ext_pin_out = 1'b1;
      end
   endtask : pulse
endmodule : timer8_pins

// >>> verification/timer8_wave_chk.sv
// Checker for the timer register port and status flags.
// Assumes it is bound onto the timer top module.
`timescale 1ns/10ps
module timer8_wave_chk
   import timer8_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   // Register port
   input wire logic [ADDR_WIDTH-1:0] awaddr_in,
   input wire logic awvalid_in,
   input wire logic awready_out,
   input wire logic wvalid_in,
   input wire logic wready_out,
   input wire logic [1:0] bresp_out,
   input wire logic bvalid_out,
   input wire logic [ADDR_WIDTH-1:0] araddr_in,
   input wire logic arvalid_in,
   input wire logic arready_out,
   input wire logic [31:0] rdata_out,
   input wire logic [1:0] rresp_out,
   input wire logic rvalid_out,
   // Status
   input wire logic [2:0] flags_out
);
   // ********
   // Captured register indices
   // ********
   logic [2:0] ar_idx_reg;
   logic [2:0] aw_idx_reg;
   always_ff @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ar_idx_reg <= 3'h0;
         aw_idx_reg <= 3'h0;
      end else begin
         if (arvalid_in && arready_out) ar_idx_reg <= araddr_in[4:2];
         if (awvalid_in && awready_out) aw_idx_reg <= awaddr_in[4:2];
      end
   end
   // ********
   // Assertions
   // ********
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rstn_in);
   sequence s_wr_take; awvalid_in && awready_out && wvalid_in && wready_out; endsequence
   sequence s_wr_resp; !bvalid_out ##1 bvalid_out; endsequence
   property p_wr_answer; s_wr_take |=> s_wr_resp; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer mistimed");
   property p_rd_answer; arvalid_in && arready_out |=> rvalid_out; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer mistimed");
   property p_b_block; bvalid_out |-> !awready_out && !wready_out; endproperty
   a_b_block: assert property (p_b_block) else $error("write taken during response");
   property p_r_block; rvalid_out |-> !arready_out; endproperty
   a_r_block: assert property (p_r_block) else $error("read taken during response");
   property p_rd_hi; rvalid_out |-> rdata_out[31:8] == 24'h0; endproperty
   a_rd_hi: assert property (p_rd_hi) else $error("read data upper bits set");
   property p_rd_rsvd; rvalid_out && ar_idx_reg == 3'h0 |-> rdata_out[3:2] == 2'h0; endproperty
   a_rd_rsvd: assert property (p_rd_rsvd) else $error("reserved bits read set");
   property p_rd_err;
      rvalid_out |-> rresp_out == ((ar_idx_reg > 3'h5) ? RESP_SLVERR : RESP_OKAY);
   endproperty
   a_rd_err: assert property (p_rd_err) else $error("read response code wrong");
   property p_wr_err;
      bvalid_out |-> bresp_out == ((aw_idx_reg > 3'h5) ? RESP_SLVERR : RESP_OKAY);
   endproperty
   a_wr_err: assert property (p_wr_err) else $error("write response code wrong");
   property p_flag_clr;
      $fell(flags_out[0]) || $fell(flags_out[1]) || $fell(flags_out[2])
         |-> aw_idx_reg == 3'h5 && (bvalid_out || $past(bvalid_out));
   endproperty
   a_flag_clr: assert property (p_flag_clr) else $error("flag fell without clear");
endmodule : timer8_wave_chk

bind timer8_wave timer8_wave_chk i_timer8_wave_chk (.ref_clk_in, .rstn_in, .awaddr_in,
   .awvalid_in, .awready_out, .wvalid_in, .wready_out, .bresp_out, .bvalid_out, .araddr_in,
   .arvalid_in, .arready_out, .rdata_out, .rresp_out, .rvalid_out, .flags_out);
